// >>> common/reader_regs.vh
// constants for the proximity reader command controller
// What the document requires
// RULE1: modulation-strength command is 43h, type byte, CRC; 01h strong, 00h normal.
// RULE2: card applies new modulation only after unselect or field reset; the card model reports it from the next read.
// RULE3: card lets the modulation setting be rewritten any number of times.
// RULE4: modulation command only after sector 0 first-key authentication.
// RULE5: reader keeps strong modulation unless the system needs normal.
// RULE6: card shows modulation in block 0 manufacturer byte: 20h strong, 00h normal.
// RULE7: authentication opens with 60h or 61h, block address, CRC.
// RULE8: card answers 4-byte challenge; reader sends 8-byte token; card answers 4 bytes.
// RULE9: authentication replies no earlier than n=9; reader times out after 1 ms.
// RULE10: reader waits at least minimum frame delay between authentication parts.
// RULE11: read 30h with address and CRC returns the 16 block bytes.
// RULE12: read reply no earlier than n=9; reader times out after 5 ms.
// RULE13: write A0h: part 1 address and CRC, part 2 sixteen data bytes.
// RULE14: write part 1 times out at 5 ms, part 2 at 10 ms.
// RULE15: reader waits at least minimum frame delay between write parts.
// RULE16: every reader frame ends with the two-byte CRC_A, checked by the card.
// RULE17: authentication identifier is the four bytes of the last cascade level.
// RULE18: card NAKs unauthenticated commands and drops frames with a bad CRC.
`ifndef READER_REGS_VH
`define READER_REGS_VH

`define CODE_AUTH_A     8'h60
`define CODE_AUTH_B     8'h61
`define CODE_READ       8'h30
`define CODE_WRITE      8'hA0
`define CODE_SET_MOD    8'h43
`define MOD_STRONG      8'h01
`define MOD_NORMAL      8'h00
`define ACK_NIBBLE      4'hA

`define OP_AUTH1        3'h0
`define OP_AUTH2        3'h1
`define OP_READ         3'h2
`define OP_WRITE        3'h3
`define OP_SET_MOD      3'h4

`define ST_OK           3'h0
`define ST_NAK          3'h1
`define ST_TIMEOUT      3'h2
`define ST_CRC_ERR      3'h3
`define ST_REFUSED      3'h4
`define ST_BAD_LEN      3'h5

`define CRC_INIT        16'h6363
`define CRC_POLY        16'h8408

`define SEC0_LAST_BLOCK 8'h03
`define BLOCK_BYTES     5'd16
`define TOKEN_BYTES     5'd8
`define CHAL_BITS       8'd32
`define READ_BITS       8'd144
`define NIBBLE_BITS     8'd4
`define RX_MAX_BYTES    5'd18

`define LINK_DIV        3'd7
`define LINK_SAMPLE     3'd3

`define CORE_NS         8
`define FC_KHZ          13560
`define FDT_N           9
`define FDT_MIN_NS      ((((`FDT_N) * 128 + 84) * 1000000 + `FC_KHZ - 1) / `FC_KHZ)
`define FDT_MIN_CYC     ((`FDT_MIN_NS + `CORE_NS - 1) / `CORE_NS)
`define TO_AUTH_MS      1
`define TO_READ_MS      5
`define TO_WR1_MS       5
`define TO_WR2_MS       10
`define TO_MOD_MS       5
`define MS_TO_CYC(ms)   ((ms) * 1000000 / `CORE_NS)

`endif

// >>> hw/rsp_buf2.v
// two-entry response byte buffer with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module rsp_buf2 (
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire       i_in_valid,
  output wire       o_in_ready,
  input  wire [8:0] i_in_data,
  output wire       o_out_valid,
  input  wire       i_out_ready,
  output wire [8:0] o_out_data
);
  reg [8:0] mem_r [0:1];
  reg       wr_ptr_r;
  reg       rd_ptr_r;
  reg [1:0] cnt_r;
  wire      push;
  wire      pop;

  assign o_in_ready  = (cnt_r != 2'd2);
  assign o_out_valid = (cnt_r != 2'd0);
  assign o_out_data  = mem_r[rd_ptr_r];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r    <= 2'd0;
      mem_r[0] <= 9'h000;
      mem_r[1] <= 9'h000;
    end else begin
      if (push) begin
        mem_r[wr_ptr_r] <= i_in_data;
        wr_ptr_r        <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 2'd1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 2'd1;
      end
    end
  end
endmodule // rsp_buf2
`default_nettype wire

// >>> hw/reader_link_ctrl.v
// proximity reader controller: frames commands to the card and collects answers
`timescale 1ns/100ps
`default_nettype none
`include "reader_regs.vh"
module reader_link_ctrl #(
  parameter [20:0] FDT_CYC     = `FDT_MIN_CYC,
  parameter [20:0] TO_AUTH_CYC = `MS_TO_CYC(`TO_AUTH_MS),
  parameter [20:0] TO_READ_CYC = `MS_TO_CYC(`TO_READ_MS),
  parameter [20:0] TO_WR1_CYC  = `MS_TO_CYC(`TO_WR1_MS),
  parameter [20:0] TO_WR2_CYC  = `MS_TO_CYC(`TO_WR2_MS),
  parameter [20:0] TO_MOD_CYC  = `MS_TO_CYC(`TO_MOD_MS)
) (
  input  wire         I_CORE_CLK,
  input  wire         I_SYS_RST,
  input  wire         I_CMD_VALID,
  output wire         O_CMD_READY,
  input  wire [2:0]   I_CMD_OP,
  input  wire         I_CMD_KEY_B,
  input  wire [7:0]   I_CMD_ADDR,
  input  wire         I_CMD_STRONG,
  input  wire         I_ALLOW_NORMAL_MOD,
  input  wire [127:0] I_CMD_DATA,
  output wire         O_RSP_VALID,
  input  wire         I_RSP_READY,
  output wire [7:0]   O_RSP_DATA,
  output wire         O_RSP_LAST,
  output reg          O_DONE,
  output reg  [2:0]   O_STATUS,
  output reg          O_AUTH_SEC0_KEYA,
  output reg          O_LINK_CLK,
  output reg          O_LINK_TX_EN,
  output reg          O_LINK_TX_D,
  input  wire         I_LINK_RX_EN,
  input  wire         I_LINK_RX_D
);
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_GAP   = 3'h1;
  localparam [2:0] S_TX    = 3'h2;
  localparam [2:0] S_WAIT  = 3'h3;
  localparam [2:0] S_RX    = 3'h4;
  localparam [2:0] S_CHECK = 3'h5;
  localparam [2:0] S_DELIV = 3'h6;
  localparam [2:0] S_FIN   = 3'h7;

  localparam [2:0] PH_AUTH1 = 3'h0;
  localparam [2:0] PH_AUTH2 = 3'h1;
  localparam [2:0] PH_READ  = 3'h2;
  localparam [2:0] PH_WR1   = 3'h3;
  localparam [2:0] PH_WR2   = 3'h4;
  localparam [2:0] PH_MOD   = 3'h5;

  reg [2:0]   state_r;
  reg [2:0]   ph_r;
  reg [7:0]   code_r;
  reg [7:0]   arg_r;
  reg [127:0] data_r;
  reg [2:0]   div_r;
  reg [4:0]   tx_idx_r;
  reg [2:0]   tx_bit_r;
  reg [15:0]  tx_crc_r;
  reg [20:0]  gap_cnt_r;
  reg [20:0]  to_cnt_r;
  reg         rx_en_m_r;
  reg         rx_en_s_r;
  reg         rx_d_m_r;
  reg         rx_d_s_r;
  reg [7:0]   rx_sh_r;
  reg [7:0]   rx_nbit_r;
  reg [15:0]  rx_crc_r;
  reg [7:0]   rx_mem_r [0:17];
  reg [4:0]   dv_idx_r;
  reg [4:0]   dv_cnt_r;
  reg [2:0]   res_r;
  reg         pend_keya_r;
  reg [4:0]   pay_len;
  reg [7:0]   tx_byte;
  reg [20:0]  to_lim;
  wire        tick_tx;
  wire        tick_rx;
  wire        buf_in_ready;
  wire        buf_push;
  wire [8:0]  buf_out;

  // one CRC_A step per byte; the same step builds the sent CRC and checks the received one
  function [15:0] crc_a_byte;
    input [15:0] crc;
    input [7:0]  d;
    integer      i;
    reg   [15:0] c;
    begin
      c = crc;
      for (i = 0; i < 8; i = i + 1) begin
        if (c[0] ^ d[i]) begin
          c = (c >> 1) ^ `CRC_POLY;
        end else begin
          c = c >> 1;
        end
      end
      crc_a_byte = c;
    end
  endfunction

  assign tick_tx     = (div_r == `LINK_DIV);
  assign tick_rx     = (div_r == `LINK_SAMPLE);
  assign O_CMD_READY = (state_r == S_IDLE);
  assign buf_push    = (state_r == S_DELIV);
  assign O_RSP_DATA  = buf_out[7:0];
  assign O_RSP_LAST  = buf_out[8];

  // payload length and current outgoing byte; CRC bytes follow the payload
  always @* begin
    case (ph_r)
      PH_AUTH2: pay_len = `TOKEN_BYTES;
      PH_WR2:   pay_len = `BLOCK_BYTES;
      default:  pay_len = 5'd2;
    endcase
    if (tx_idx_r == pay_len) begin
      tx_byte = tx_crc_r[7:0]; // RULE16
    end else if (tx_idx_r == pay_len + 5'd1) begin
      tx_byte = tx_crc_r[15:8]; // RULE16
    end else if (ph_r == PH_AUTH2 || ph_r == PH_WR2) begin
      tx_byte = data_r[{tx_idx_r[3:0], 3'b000} +: 8]; // RULE8 RULE13
    end else if (tx_idx_r == 5'd0) begin
      tx_byte = code_r;
    end else begin
      tx_byte = arg_r;
    end
  end

  always @* begin
    case (ph_r)
      PH_AUTH1: to_lim = TO_AUTH_CYC; // RULE9
      PH_AUTH2: to_lim = TO_AUTH_CYC; // RULE9
      PH_READ:  to_lim = TO_READ_CYC; // RULE12
      PH_WR1:   to_lim = TO_WR1_CYC;  // RULE14
      PH_WR2:   to_lim = TO_WR2_CYC;  // RULE14
      default:  to_lim = TO_MOD_CYC;
    endcase
  end

  // the link clock is a divided core clock, so it runs free and the card can time its replies
  always @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      div_r      <= 3'd0;
      O_LINK_CLK <= 1'b0;
      rx_en_m_r  <= 1'b0;
      rx_en_s_r  <= 1'b0;
      rx_d_m_r   <= 1'b0;
      rx_d_s_r   <= 1'b0;
    end else begin
      div_r      <= div_r + 3'd1;
      O_LINK_CLK <= (div_r >= 3'd3) && (div_r != `LINK_DIV);
      rx_en_m_r  <= I_LINK_RX_EN;
      rx_en_s_r  <= rx_en_m_r;
      rx_d_m_r   <= I_LINK_RX_D;
      rx_d_s_r   <= rx_d_m_r;
    end
  end

  always @(posedge I_CORE_CLK) begin
    if (I_SYS_RST) begin
      state_r          <= S_IDLE;
      ph_r             <= PH_AUTH1;
      code_r           <= 8'h00;
      arg_r            <= 8'h00;
      data_r           <= 128'h0;
      tx_idx_r         <= 5'd0;
      tx_bit_r         <= 3'd0;
      tx_crc_r         <= `CRC_INIT;
      gap_cnt_r        <= FDT_CYC;
      to_cnt_r         <= 21'd0;
      rx_sh_r          <= 8'h00;
      rx_nbit_r        <= 8'h00;
      rx_crc_r         <= `CRC_INIT;
      dv_idx_r         <= 5'd0;
      dv_cnt_r         <= 5'd0;
      res_r            <= `ST_OK;
      pend_keya_r      <= 1'b0;
      O_DONE           <= 1'b0;
      O_STATUS         <= `ST_OK;
      O_AUTH_SEC0_KEYA <= 1'b0;
      O_LINK_TX_EN     <= 1'b0;
      O_LINK_TX_D      <= 1'b0;
    end else begin
      O_DONE <= 1'b0;
      if (gap_cnt_r != FDT_CYC) begin
        gap_cnt_r <= gap_cnt_r + 21'd1;
      end
      case (state_r)
        S_IDLE: begin
          if (I_CMD_VALID) begin
            data_r   <= I_CMD_DATA;
            arg_r    <= I_CMD_ADDR;
            state_r  <= S_GAP;
            case (I_CMD_OP)
              `OP_AUTH1: begin
                ph_r        <= PH_AUTH1;
                code_r      <= I_CMD_KEY_B ? `CODE_AUTH_B : `CODE_AUTH_A; // RULE7
                pend_keya_r <= !I_CMD_KEY_B && (I_CMD_ADDR <= `SEC0_LAST_BLOCK);
              end
              // the token is computed outside from the last cascade level identifier
              `OP_AUTH2: ph_r <= PH_AUTH2; // RULE8 RULE17
              `OP_READ: begin
                ph_r   <= PH_READ;
                code_r <= `CODE_READ; // RULE11
              end
              `OP_WRITE: begin
                ph_r   <= PH_WR1;
                code_r <= `CODE_WRITE; // RULE13
              end
              `OP_SET_MOD: begin
                ph_r   <= PH_MOD;
                code_r <= `CODE_SET_MOD; // RULE1
                arg_r  <= I_CMD_STRONG ? `MOD_STRONG : `MOD_NORMAL; // RULE1
                // normal modulation needs the explicit system enable
                if (!O_AUTH_SEC0_KEYA || (!I_CMD_STRONG && !I_ALLOW_NORMAL_MOD)) begin // RULE4 RULE5
                  res_r   <= `ST_REFUSED;
                  state_r <= S_FIN;
                end
              end
              default: begin
                res_r   <= `ST_REFUSED;
                state_r <= S_FIN;
              end
            endcase
          end
        end
        S_GAP: begin
          tx_idx_r <= 5'd0;
          tx_bit_r <= 3'd0;
          tx_crc_r <= `CRC_INIT;
          if (gap_cnt_r == FDT_CYC && tick_tx) begin // RULE10 RULE15
            state_r <= S_TX;
          end
        end
        S_TX: begin
          if (tick_tx) begin
            if (tx_idx_r == pay_len + 5'd2) begin
              O_LINK_TX_EN <= 1'b0;
              O_LINK_TX_D  <= 1'b0;
              to_cnt_r     <= 21'd0;
              rx_nbit_r    <= 8'h00;
              rx_crc_r     <= `CRC_INIT;
              gap_cnt_r    <= 21'd0;
              state_r      <= S_WAIT;
            end else begin
              O_LINK_TX_EN <= 1'b1;
              O_LINK_TX_D  <= tx_byte[tx_bit_r];
              tx_bit_r     <= tx_bit_r + 3'd1;
              if (tx_bit_r == 3'd7) begin
                tx_idx_r <= tx_idx_r + 5'd1;
                if (tx_idx_r < pay_len) begin
                  tx_crc_r <= crc_a_byte(tx_crc_r, tx_byte); // RULE16
                end
              end
            end
          end
        end
        S_WAIT, S_RX: begin
          if (state_r == S_WAIT) begin
            to_cnt_r <= to_cnt_r + 21'd1;
          end
          if (state_r == S_WAIT && to_cnt_r == to_lim) begin // RULE9 RULE12 RULE14
            res_r     <= `ST_TIMEOUT;
            gap_cnt_r <= 21'd0;
            state_r   <= S_FIN;
          end else if (tick_rx && rx_en_s_r) begin
            state_r <= S_RX;
            rx_sh_r <= {rx_d_s_r, rx_sh_r[7:1]};
            if (rx_nbit_r != 8'hFF) begin
              rx_nbit_r <= rx_nbit_r + 8'd1;
            end
            if (rx_nbit_r[2:0] == 3'd7 && rx_nbit_r[7:3] < `RX_MAX_BYTES) begin
              rx_mem_r[rx_nbit_r[7:3]] <= {rx_d_s_r, rx_sh_r[7:1]};
              rx_crc_r <= crc_a_byte(rx_crc_r, {rx_d_s_r, rx_sh_r[7:1]}); // RULE16
            end
          end else if (tick_rx && state_r == S_RX) begin
            gap_cnt_r <= 21'd0;
            state_r   <= S_CHECK;
          end
        end
        S_CHECK: begin
          dv_idx_r <= 5'd0;
          dv_cnt_r <= 5'd0;
          state_r  <= S_FIN;
          if (rx_nbit_r == `NIBBLE_BITS) begin
            if (rx_sh_r[7:4] == `ACK_NIBBLE && (ph_r >= PH_WR1)) begin
              res_r <= `ST_OK;
              if (ph_r == PH_WR1) begin
                ph_r    <= PH_WR2; // RULE13
                state_r <= S_GAP;
              end
            end else begin
              res_r <= `ST_NAK;
            end
          end else if ((ph_r == PH_AUTH1 || ph_r == PH_AUTH2) && rx_nbit_r == `CHAL_BITS) begin
            res_r    <= `ST_OK; // RULE8
            dv_cnt_r <= 5'd4;
            state_r  <= S_DELIV;
          end else if (ph_r == PH_READ && rx_nbit_r == `READ_BITS) begin
            if (rx_crc_r == 16'h0000) begin // RULE16
              res_r    <= `ST_OK;
              dv_cnt_r <= `BLOCK_BYTES; // RULE11
              state_r  <= S_DELIV;
            end else begin
              res_r <= `ST_CRC_ERR;
            end
          end else begin
            res_r <= `ST_BAD_LEN;
          end
        end
        S_DELIV: begin
          // a stalled consumer holds the controller here, so no answer byte is dropped
          if (buf_in_ready) begin
            dv_idx_r <= dv_idx_r + 5'd1;
            if (dv_idx_r == dv_cnt_r - 5'd1) begin
              state_r <= S_FIN;
            end
          end
        end
        S_FIN: begin
          O_DONE   <= 1'b1;
          O_STATUS <= res_r;
          state_r  <= S_IDLE;
          if (ph_r == PH_AUTH1 || ph_r == PH_AUTH2) begin
            O_AUTH_SEC0_KEYA <= (ph_r == PH_AUTH2) && (res_r == `ST_OK) && pend_keya_r; // RULE4
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  rsp_buf2 u_rsp_buf (
    .i_clk       (I_CORE_CLK),
    .i_rst       (I_SYS_RST),
    .i_in_valid  (buf_push),
    .o_in_ready  (buf_in_ready),
    .i_in_data   ({dv_idx_r == dv_cnt_r - 5'd1, rx_mem_r[dv_idx_r]}),
    .o_out_valid (O_RSP_VALID),
    .i_out_ready (I_RSP_READY),
    .o_out_data  (buf_out)
  );
endmodule // reader_link_ctrl
`default_nettype wire

// >>> tb/reader_link_ctrl_checker.sv
// port-level assertions for the reader controller
`timescale 1ns/100ps
`default_nettype none
`include "reader_regs.vh"
module reader_link_ctrl_checker #(
  parameter [20:0] FDT_CYC = 21'd20
) (
  input wire logic       I_CORE_CLK,
  input wire logic       I_SYS_RST,
  input wire logic       I_CMD_VALID,
  input wire logic       O_CMD_READY,
  input wire logic [2:0] I_CMD_OP,
  input wire logic       I_CMD_STRONG,
  input wire logic       I_ALLOW_NORMAL_MOD,
  input wire logic       I_RSP_READY,
  input wire logic       O_RSP_VALID,
  input wire logic [7:0] O_RSP_DATA,
  input wire logic       O_RSP_LAST,
  input wire logic       O_DONE,
  input wire logic [2:0] O_STATUS,
  input wire logic       O_AUTH_SEC0_KEYA,
  input wire logic       O_LINK_CLK,
  input wire logic       O_LINK_TX_EN,
  input wire logic       O_LINK_TX_D,
  input wire logic       I_LINK_RX_EN
);
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  wire         take   = I_CMD_VALID && O_CMD_READY;
  wire         is_mod = take && (I_CMD_OP == `OP_SET_MOD);
  logic [20:0] quiet_r;

  // raw rx enable ends before the design's synced copy, so this count never runs late
  always @(posedge I_CORE_CLK) begin
    if (I_SYS_RST)
      quiet_r <= FDT_CYC;
    else if (O_LINK_TX_EN || I_LINK_RX_EN)
      quiet_r <= 21'd0;
    else if (quiet_r < FDT_CYC)
      quiet_r <= quiet_r + 21'd1;
  end

  sequence s_refused;
    !O_LINK_TX_EN && !O_DONE ##1 !O_LINK_TX_EN && O_DONE && O_STATUS == `ST_REFUSED;
  endsequence

  a_mod_needs_keya: assert property (is_mod && !O_AUTH_SEC0_KEYA |=> s_refused)
    else $error("modulation command sent without first-key session");
  a_normal_needs_allow: assert property (
    is_mod && !I_CMD_STRONG && !I_ALLOW_NORMAL_MOD |=> s_refused)
    else $error("normal modulation sent without permission");
  a_bad_op_refused: assert property (take && I_CMD_OP > `OP_SET_MOD |=> s_refused)
    else $error("unknown operation not refused");
  a_done_pulse: assert property (O_DONE |=> !O_DONE)
    else $error("done longer than one cycle");
  a_busy_after_take: assert property (take |=> !O_CMD_READY)
    else $error("ready while busy");
  a_ready_after_done: assert property (O_DONE |-> O_CMD_READY && !$past(O_CMD_READY))
    else $error("ready not back after done");
  a_status_holds: assert property ($changed(O_STATUS) |-> O_DONE)
    else $error("status moved without done");
  a_rsp_hold: assert property (O_RSP_VALID && !I_RSP_READY |=>
    O_RSP_VALID && $stable(O_RSP_DATA) && $stable(O_RSP_LAST))
    else $error("stalled answer byte changed");
  a_link_clk_shape: assert property ($rose(O_LINK_CLK) |->
    O_LINK_CLK [*4] ##1 !O_LINK_CLK [*4] ##1 O_LINK_CLK)
    else $error("link clock not four high four low");
  a_txd_steady: assert property (O_LINK_TX_EN && O_LINK_CLK && $past(O_LINK_TX_EN) &&
    $past(O_LINK_CLK) |-> $stable(O_LINK_TX_D))
    else $error("tx bit moved in high phase");
  a_frame_gap: assert property ($rose(O_LINK_TX_EN) |-> quiet_r >= FDT_CYC - 21'd1)
    else $error("frame started inside the guard gap");
endmodule // reader_link_ctrl_checker
bind reader_link_ctrl reader_link_ctrl_checker #(.FDT_CYC(FDT_CYC)) u_chk (.*);
`default_nettype wire

// >>> tb/proximity_card_model.sv
// card-side model: decodes reader frames, answers them and holds the block memory
`timescale 1ns/100ps
`default_nettype none
`include "reader_regs.vh"
module proximity_card_model #(
  parameter int    MB   = 5,            // block 0 byte that reports modulation, plain default
  parameter [31:0] CHAL = 32'h5A3C96E1  // challenge value, arbitrary
) (
  input  wire logic       i_link_clk,
  input  wire logic       i_tx_en,
  input  wire logic       i_tx_d,
  input  wire logic       i_mute,
  input  wire logic [7:0] i_dly,
  output var  logic       o_rx_en,
  output var  logic       o_rx_d
);
  logic [127:0] mem [0:255];
  logic [7:0]   rxb [0:31];
  logic [7:0]   txb [0:17];
  int           nbit;
  int           tn;
  logic         in_fr, authd, keya, ka_p, a_pend, w_pend, strong_cfg;
  logic [7:0]   w_blk;

  function automatic [15:0] crc_step(input [15:0] c, input [7:0] d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) x = x[0] ? ((x >> 1) ^ `CRC_POLY) : (x >> 1);
    return x;
  endfunction

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = {16{i[7:0]}};
    {o_rx_en, o_rx_d, in_fr, authd, keya, ka_p, a_pend, w_pend} = '0;
    strong_cfg = 1'b1;
    nbit = 0;
  end

  // reader bits change on the falling link clock, so take them on the rising one
  always @(posedge i_link_clk) begin
    if (i_tx_en === 1'b1) begin
      if (!in_fr) nbit = 0;
      rxb[nbit >> 3][nbit % 8] = i_tx_d;
      nbit = nbit + 1;
    end
    in_fr = (i_tx_en === 1'b1);
  end

  always @(negedge i_tx_en) begin : frame
    logic [15:0] c;
    int          nby;
    nby = nbit / 8;
    c = `CRC_INIT;
    for (int k = 0; k < nby; k++) c = crc_step(c, rxb[k]);
    tn = 0;
    if (nby >= 3 && c == 16'h0000 && !i_mute) begin
      txb[0] = {4'h0, `ACK_NIBBLE};
      if (w_pend && nby == 18) begin
        for (int k = 0; k < 16; k++) mem[w_blk][8*k +: 8] = rxb[k];
        w_pend = 1'b0;
        tn = 4;
      end else if (a_pend && nby == 10) begin
        for (int k = 0; k < 4; k++) txb[k] = ~rxb[k];
        {authd, keya, a_pend} = {1'b1, ka_p, 1'b0};
        tn = 32;
      end else begin
        case (rxb[0])
          `CODE_AUTH_A, `CODE_AUTH_B: begin
            ka_p = (rxb[0] == `CODE_AUTH_A) && (rxb[1] <= `SEC0_LAST_BLOCK);
            {authd, keya, a_pend, w_pend} = 4'b0010;
            for (int k = 0; k < 4; k++) txb[k] = CHAL[8*k +: 8];
            tn = 32;
          end
          `CODE_READ: if (authd) begin
            for (int k = 0; k < 16; k++) txb[k] = mem[rxb[1]][8*k +: 8];
            if (rxb[1] == 8'h00) txb[MB] = strong_cfg ? 8'h20 : 8'h00;
            c = `CRC_INIT;
            for (int k = 0; k < 16; k++) c = crc_step(c, txb[k]);
            {txb[17], txb[16]} = c;
            tn = 144;
          end
          `CODE_WRITE: if (authd) begin
            {w_blk, w_pend, tn} = {rxb[1], 1'b1, 32'd4};
          end
          `CODE_SET_MOD: if (keya) begin
            // only the configured value moves, and block 0 reports that value from the next read
            strong_cfg = rxb[1][0];
            tn = 4;
          end
          default: ;
        endcase
      end
      if (tn == 0) begin
        txb[0] = 8'h04;
        tn = 4;
      end
    end
    if (tn > 0) begin
      repeat (i_dly) @(posedge i_link_clk);
      o_rx_en = 1'b1;
      for (int b = 0; b < tn; b++) begin
        o_rx_d = txb[b / 8][b % 8];
        @(posedge i_link_clk);
      end
      o_rx_en = 1'b0;
      // released data line must not keep showing the last bit
      o_rx_d = ~o_rx_d;
    end
  end
endmodule // proximity_card_model
`default_nettype wire

// >>> tb/reader_link_ctrl_tb.sv
// testbench: reader controller against the card model
`timescale 1ns/100ps
`default_nettype none
`include "reader_regs.vh"
module reader_link_ctrl_tb;
  localparam int     MB   = 5;
  localparam [31:0]  CHAL = 32'h5A3C96E1;
  localparam [127:0] TOK  = 128'h1122334455667788;
  localparam [127:0] WD   = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
  logic         I_CORE_CLK, I_SYS_RST, I_CMD_VALID, I_CMD_KEY_B, I_CMD_STRONG;
  logic         I_ALLOW_NORMAL_MOD, I_RSP_READY, O_CMD_READY, O_RSP_VALID, O_RSP_LAST;
  logic         O_DONE, O_AUTH_SEC0_KEYA, O_LINK_CLK, O_LINK_TX_EN, O_LINK_TX_D;
  logic         I_LINK_RX_EN, I_LINK_RX_D, mute, stall;
  logic [2:0]   I_CMD_OP, O_STATUS;
  logic [2:0]   cyc = 3'h0;
  logic [7:0]   I_CMD_ADDR, O_RSP_DATA, dly;
  logic [127:0] I_CMD_DATA;
  logic [8:0]   rq [$];
  int           err_total, n_tests;

  reader_link_ctrl #(.FDT_CYC(21'd20), .TO_AUTH_CYC(21'd2000), .TO_READ_CYC(21'd2000),
    .TO_WR1_CYC(21'd2000), .TO_WR2_CYC(21'd2000)) dut (.*);
  // the card always answers a modulation command, so its timeout keeps the full default
  proximity_card_model #(.MB(MB), .CHAL(CHAL)) u_card (.i_link_clk(O_LINK_CLK),
    .i_tx_en(O_LINK_TX_EN), .i_tx_d(O_LINK_TX_D), .i_mute(mute), .i_dly(dly),
    .o_rx_en(I_LINK_RX_EN), .o_rx_d(I_LINK_RX_D));

  initial begin
    I_CORE_CLK = 1'b0;
    forever #4 I_CORE_CLK = ~I_CORE_CLK;
  end
  always @(posedge I_CORE_CLK) begin
    if (O_RSP_VALID === 1'b1 && I_RSP_READY === 1'b1) rq.push_back({O_RSP_LAST, O_RSP_DATA});
  end
  // ready one cycle in eight while stalling, so the two-entry buffer fills and refuses
  always @(negedge I_CORE_CLK) begin
    cyc <= cyc + 3'h1;
    I_RSP_READY <= !stall || (cyc == 3'h0);
  end

  task automatic chk(input [127:0] got, input [127:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (err_total == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic run(input [2:0] op, input [7:0] ad, input kb, input st, input [127:0] dt,
                     input [2:0] es, input int nb, input [127:0] ex);
    int i;
    rq.delete();
    @(negedge I_CORE_CLK);
    {I_CMD_OP, I_CMD_ADDR, I_CMD_KEY_B, I_CMD_STRONG, I_CMD_DATA} = {op, ad, kb, st, dt};
    I_CMD_VALID = 1'b1;
    @(negedge I_CORE_CLK);
    I_CMD_VALID = 1'b0;
    for (i = 0; i < 20000 && O_DONE !== 1'b1; i++) @(negedge I_CORE_CLK);
    if (i == 20000) begin
      chk(1, 0);
      complete_run();
    end
    chk(O_STATUS, es);
    for (int j = 0; j < 300 && rq.size() < nb; j++) @(negedge I_CORE_CLK);
    chk(rq.size(), nb);
    for (int k = 0; k < nb; k++) chk(rq[k], {k == nb - 1, ex[8*k +: 8]});
  endtask

  task automatic sc_unauth;
    run(`OP_READ, 8'h04, 0, 1, 0, `ST_NAK, 0, 0);
    run(`OP_WRITE, 8'h04, 0, 1, 0, `ST_NAK, 0, 0);
    for (int op = 4; op < 8; op++) run(op[2:0], 0, 0, 1, 0, `ST_REFUSED, 0, 0);
  endtask
  task automatic sc_auth(input kb, input [7:0] blk, input ka);
    run(`OP_AUTH1, blk, kb, 1, 0, `ST_OK, 4, CHAL);
    run(`OP_AUTH2, blk, kb, 1, TOK, `ST_OK, 4, ~TOK);
    chk(O_AUTH_SEC0_KEYA, ka);
  endtask
  task automatic sc_mod;
    sc_auth(0, 8'h02, 1);
    run(`OP_SET_MOD, 0, 0, 0, 0, `ST_REFUSED, 0, 0);
    I_ALLOW_NORMAL_MOD = 1'b1;
    for (int s = 0; s < 3; s++) begin
      run(`OP_SET_MOD, 0, 0, s[0], 0, `ST_OK, 0, 0);
      dly = s[0] ? 8'd200 : 8'd4;
      run(`OP_READ, 0, 0, 1, 0, `ST_OK, 16, s[0] ? (128'h20 << (8*MB)) : 0);
      dly = 8'd4;
    end
  endtask
  task automatic sc_write;
    run(`OP_WRITE, 8'h09, 0, 1, WD, `ST_OK, 0, 0);
    stall = 1'b1;
    run(`OP_READ, 8'h09, 0, 1, 0, `ST_OK, 16, WD);
    stall = 1'b0;
    run(`OP_READ, 8'h07, 0, 1, 0, `ST_OK, 16, {16{8'h07}});
    chk(O_RSP_VALID, 0);
  endtask
  task automatic sc_silent;
    mute = 1'b1;
    run(`OP_READ, 8'h09, 0, 1, 0, `ST_TIMEOUT, 0, 0);
    run(`OP_AUTH1, 8'h00, 0, 1, 0, `ST_TIMEOUT, 0, 0);
    mute = 1'b0;
    chk(O_AUTH_SEC0_KEYA, 0);
    sc_auth(1, 8'h01, 0);
    run(`OP_SET_MOD, 0, 0, 1, 0, `ST_REFUSED, 0, 0);
  endtask

  initial begin
    I_SYS_RST = 1'b1;
    {I_CMD_VALID, I_CMD_KEY_B, I_ALLOW_NORMAL_MOD, stall, mute} = '0;
    {I_CMD_OP, I_CMD_ADDR, I_CMD_STRONG, I_CMD_DATA} = '0;
    dly = 8'd4;
    err_total = 0;
    n_tests = 0;
    repeat (6) @(negedge I_CORE_CLK);
    I_SYS_RST = 1'b0;
    chk({O_CMD_READY, O_STATUS, O_AUTH_SEC0_KEYA, O_LINK_TX_EN, O_RSP_VALID}, 7'h40);
    sc_unauth();
    sc_mod();
    sc_write();
    sc_silent();
    complete_run();
  end
endmodule // reader_link_ctrl_tb
`default_nettype wire
